// *** rtl/cpu_dram_refresh_glue.sv ***
module cpu_dram_refresh_glue (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // processor bus
    input wire dram_glue_pkg::cpu_bus_t cpuBus,
    input wire logic waitOnRead,
    input wire logic waitOnWrite,
    // refresh and configuration
    input wire logic refreshPeriodClock,
    input wire logic hidden_refresh_enable,
    input wire logic outputEnable_n,
    // outputs toward processor and controller
    output logic access_done_flag,
    output logic row_strobe_request,
    output logic transfer_ack,
    output logic access_during_refresh,
    output logic controller_mode_pin,
    output logic refresh_request,
    output logic outputsDriven_n
);
    typedef struct packed {
        dram_glue_pkg::seq_t seq;
        logic delay_stage_two;
        logic delay_stage_three;
        logic delay_stage_four;
        logic [2:0] waitCount;
        logic hiddenCycle;
        logic doneFlag;
        logic ack;
        logic rowReq;
        logic inRefresh;
        logic modeLow;
    } glue_t;

    glue_t cur;
    glue_t next_cur;
    logic forcedActive;
    logic recovering;
    logic arbRequest;
    logic strobe;
    logic selected;
    logic refreshBlocked;
    logic waitWanted;
    logic hiddenDone;
    logic dramBusy;

    assign strobe = !cpuBus.addressStrobe_n;
    assign selected = strobe && !cpuBus.chipSelect_n;
    assign refreshBlocked = forcedActive || recovering;
    // wait input gated per direction so read, write or both can stretch
    assign waitWanted = !cpuBus.waitRequest_n && (cpuBus.readWrite ? waitOnRead : waitOnWrite);
    assign hiddenDone = cur.hiddenCycle && cur.delay_stage_three;
    // an access held off by a refresh does not count as busy
    assign dramBusy = selected && !cur.inRefresh;

    refresh_arbiter #(
        .CNT_W(4)
    ) u_arb (
        .sys_clk(sys_clk),
        .rst(rst),
        .refreshPeriodClock(refreshPeriodClock),
        .hiddenDone(hiddenDone),
        .dramBusy(dramBusy),
        .forcedActive(forcedActive),
        .recovering(recovering),
        .refreshRequest(arbRequest)
    );

    always_comb begin
        next_cur = cur;
        next_cur.modeLow = forcedActive;
        next_cur.inRefresh = selected && refreshBlocked;
        unique case (cur.seq)
            dram_glue_pkg::ST_IDLE: begin
                next_cur.delay_stage_two = 1'b0;
                next_cur.delay_stage_three = 1'b0;
                next_cur.delay_stage_four = 1'b0;
                next_cur.ack = 1'b0;
                next_cur.rowReq = 1'b0;
                next_cur.hiddenCycle = 1'b0;
                next_cur.doneFlag = 1'b0;
                if (selected && !refreshBlocked) begin
                    // row request at next edge, start of S3 for reads
                    next_cur.rowReq = 1'b1;
                    next_cur.seq = dram_glue_pkg::ST_D2;
                    next_cur.waitCount = waitWanted ? dram_glue_pkg::WAIT_CYCLES : 3'h0;
                end else if (strobe && cpuBus.chipSelect_n && hidden_refresh_enable
                        && refreshPeriodClock && !refreshBlocked) begin
                    // foreign access used for a hidden refresh
                    next_cur.rowReq = 1'b1;
                    next_cur.hiddenCycle = 1'b1;
                    next_cur.seq = dram_glue_pkg::ST_D2;
                    next_cur.waitCount = 3'h0;
                end
            end
            dram_glue_pkg::ST_D2: begin
                next_cur.delay_stage_two = 1'b1;
                next_cur.seq = dram_glue_pkg::ST_D3;
            end
            dram_glue_pkg::ST_D3: begin
                next_cur.delay_stage_three = 1'b1;
                if (cur.waitCount == 3'h0) begin
                    next_cur.seq = dram_glue_pkg::ST_D4;
                    next_cur.ack = !cur.hiddenCycle;
                end else begin
                    next_cur.waitCount = cur.waitCount - 3'h1;
                end
            end
            dram_glue_pkg::ST_D4: begin
                next_cur.delay_stage_four = 1'b1;
                next_cur.doneFlag = 1'b1;
                next_cur.seq = dram_glue_pkg::ST_DONE;
            end
            dram_glue_pkg::ST_DONE: begin
                // row strobe held low through the whole strobe so a
                // test-and-set gets two column strobes in one page
                if (!strobe || cpuBus.anyByteStrobe_n && cur.delay_stage_four && !strobe) begin
                    next_cur.seq = dram_glue_pkg::ST_IDLE;
                    next_cur.doneFlag = 1'b0;
                    next_cur.ack = 1'b0;
                    next_cur.rowReq = 1'b0;
                end else begin
                    next_cur.ack = !cur.hiddenCycle && !cpuBus.anyByteStrobe_n;
                end
            end
        endcase
        if (!strobe) begin
            next_cur.seq = dram_glue_pkg::ST_IDLE;
            next_cur.rowReq = 1'b0;
            next_cur.ack = 1'b0;
            next_cur.doneFlag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur <= '{seq: dram_glue_pkg::ST_IDLE, waitCount: 3'h0, default: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    // outputs are active low; held inactive while enable is high
    assign outputsDriven_n = outputEnable_n;
    assign access_done_flag = outputEnable_n ? 1'b1 : !cur.doneFlag;
    assign row_strobe_request = outputEnable_n ? 1'b1 : !cur.rowReq;
    assign transfer_ack = outputEnable_n ? 1'b1 : !cur.ack;
    assign access_during_refresh = outputEnable_n ? 1'b1 : !cur.inRefresh;
    assign controller_mode_pin = outputEnable_n ? 1'b1 : !cur.modeLow;
    assign refresh_request = outputEnable_n ? 1'b1 : !arbRequest;

    property p_row_after_strobe;
        @(posedge sys_clk) disable iff (rst)
        $rose(cur.rowReq) |-> $past(strobe);
    endproperty
    a_row_after_strobe: assert property (p_row_after_strobe) else $error("row request without strobe");

    property p_hidden_disabled;
        @(posedge sys_clk) disable iff (rst)
        $rose(cur.rowReq) && !$past(hidden_refresh_enable) |-> !cur.hiddenCycle;
    endproperty
    a_hidden_disabled: assert property (p_hidden_disabled) else $error("hidden refresh while disabled");

    property p_done_clears;
        @(posedge sys_clk) disable iff (rst)
        !strobe |=> !cur.doneFlag;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("done flag not cleared");

    property p_done_after_stages;
        @(posedge sys_clk) disable iff (rst)
        $rose(cur.doneFlag) |-> cur.delay_stage_two && cur.delay_stage_three;
    endproperty
    a_done_after_stages: assert property (p_done_after_stages) else $error("done before stages");

    property p_no_wait_timing;
        @(posedge sys_clk) disable iff (rst)
        $rose(cur.rowReq) && cur.waitCount == 3'h0 && !cur.hiddenCycle && strobe ##1 strobe |-> !cur.ack ##1 cur.ack;
    endproperty
    a_no_wait_timing: assert property (p_no_wait_timing) else $error("ack late without wait");

    property p_one_wait;
        @(posedge sys_clk) disable iff (rst)
        $rose(cur.rowReq) && cur.waitCount == 3'h1 && strobe ##1 strobe[*2] |-> !cur.ack ##1 cur.ack;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state not one cycle");

    property p_hidden_no_ack;
        @(posedge sys_clk) disable iff (rst)
        cur.hiddenCycle |-> !cur.ack;
    endproperty
    a_hidden_no_ack: assert property (p_hidden_no_ack) else $error("ack on hidden refresh");

    property p_mode_follows;
        @(posedge sys_clk) disable iff (rst)
        forcedActive |=> cur.modeLow;
    endproperty
    a_mode_follows: assert property (p_mode_follows) else $error("mode pin not low in refresh");

    property p_no_access_in_refresh;
        @(posedge sys_clk) disable iff (rst)
        refreshBlocked && cur.seq == dram_glue_pkg::ST_IDLE |=> !$rose(cur.rowReq);
    endproperty
    a_no_access_in_refresh: assert property (p_no_access_in_refresh) else $error("access started in refresh");

    property p_flag_in_refresh;
        @(posedge sys_clk) disable iff (rst)
        selected && refreshBlocked |=> cur.inRefresh;
    endproperty
    a_flag_in_refresh: assert property (p_flag_in_refresh) else $error("access flag missing");

    property p_row_on_select;
        @(posedge sys_clk) disable iff (rst)
        cur.seq == dram_glue_pkg::ST_IDLE && selected && !refreshBlocked |=> cur.rowReq && !cur.hiddenCycle;
    endproperty
    a_row_on_select: assert property (p_row_on_select) else $error("row request missing on select");

    property p_hidden_start;
        @(posedge sys_clk) disable iff (rst)
        cur.seq == dram_glue_pkg::ST_IDLE && strobe && cpuBus.chipSelect_n && hidden_refresh_enable
            && refreshPeriodClock && !refreshBlocked |=> cur.rowReq && cur.hiddenCycle;
    endproperty
    a_hidden_start: assert property (p_hidden_start) else $error("hidden refresh not started");

    property p_hidden_off;
        @(posedge sys_clk) disable iff (rst)
        cur.seq == dram_glue_pkg::ST_IDLE && !hidden_refresh_enable && !selected |=> !cur.rowReq;
    endproperty
    a_hidden_off: assert property (p_hidden_off) else $error("row request without select");

    property p_hidden_no_wait;
        @(posedge sys_clk) disable iff (rst)
        $rose(cur.hiddenCycle) |-> cur.waitCount == 3'h0;
    endproperty
    a_hidden_no_wait: assert property (p_hidden_no_wait) else $error("wait loaded on hidden refresh");

    property p_wait_loaded;
        @(posedge sys_clk) disable iff (rst)
        cur.seq == dram_glue_pkg::ST_IDLE && selected && !refreshBlocked && waitWanted
            |=> cur.waitCount == dram_glue_pkg::WAIT_CYCLES;
    endproperty
    a_wait_loaded: assert property (p_wait_loaded) else $error("wait state not loaded");

    property p_no_wait_loaded;
        @(posedge sys_clk) disable iff (rst)
        cur.seq == dram_glue_pkg::ST_IDLE && selected && !refreshBlocked && !waitWanted |=> cur.waitCount == 3'h0;
    endproperty
    a_no_wait_loaded: assert property (p_no_wait_loaded) else $error("wait state not wanted");

    property p_stage_order;
        @(posedge sys_clk) disable iff (rst)
        cur.delay_stage_three |-> cur.delay_stage_two;
    endproperty
    a_stage_order: assert property (p_stage_order) else $error("stage three before stage two");

    property p_stage_four;
        @(posedge sys_clk) disable iff (rst)
        cur.delay_stage_four |-> cur.delay_stage_three;
    endproperty
    a_stage_four: assert property (p_stage_four) else $error("stage four before stage three");

    property p_done_in_strobe;
        @(posedge sys_clk) disable iff (rst)
        cur.doneFlag |-> $past(strobe);
    endproperty
    a_done_in_strobe: assert property (p_done_in_strobe) else $error("done flag outside strobe");

    property p_ack_clears;
        @(posedge sys_clk) disable iff (rst)
        !strobe |=> !cur.ack && !cur.rowReq;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("row or ack held after strobe");

    property p_forced_idle;
        @(posedge sys_clk) disable iff (rst)
        $rose(forcedActive) |-> !$past(dramBusy);
    endproperty
    a_forced_idle: assert property (p_forced_idle) else $error("forced refresh during access");

    property p_request_on_fall;
        @(posedge sys_clk) disable iff (rst)
        $rose(arbRequest) |-> !$past(refreshPeriodClock) && $past(refreshPeriodClock, 2);
    endproperty
    a_request_on_fall: assert property (p_request_on_fall) else $error("request without period fall");

    property p_no_ack_in_refresh;
        @(posedge sys_clk) disable iff (rst)
        cur.inRefresh |-> !cur.ack;
    endproperty
    a_no_ack_in_refresh: assert property (p_no_ack_in_refresh) else $error("ack while held by refresh");

    property p_mode_drops;
        @(posedge sys_clk) disable iff (rst)
        !forcedActive |=> !cur.modeLow;
    endproperty
    a_mode_drops: assert property (p_mode_drops) else $error("mode pin low outside refresh");

    c_access: cover property (@(posedge sys_clk) disable iff (rst) $rose(cur.ack));
    c_hidden: cover property (@(posedge sys_clk) disable iff (rst) $rose(cur.hiddenCycle));
    c_forced: cover property (@(posedge sys_clk) disable iff (rst) $rose(cur.modeLow));
    c_blocked: cover property (@(posedge sys_clk) disable iff (rst) $rose(cur.inRefresh));
    c_test_and_set: cover property (@(posedge sys_clk) disable iff (rst)
        cur.seq == dram_glue_pkg::ST_DONE && cur.ack ##1 !cur.ack ##1 cur.ack);
endmodule

// *** shared/dram_glue_pkg.sv ***
package dram_glue_pkg;
    // delay-stage sequence, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_D2 = 5'h02,
        ST_D3 = 5'h04,
        ST_D4 = 5'h08,
        ST_DONE = 5'h10
    } seq_t;

    // processor bus inputs, all low-active except the readWrite level (high for a read)
    typedef struct packed {
        logic addressStrobe_n;
        logic chipSelect_n;
        logic readWrite;
        logic anyByteStrobe_n;
        logic waitRequest_n;
    } cpu_bus_t;

    localparam logic [2:0] WAIT_CYCLES = 3'h1;
    localparam int RAS_PRECHARGE_NS = 150;
    localparam int CLK_PERIOD_NS = 100;
    // least time rounds up for precharge, down for forced refresh; never below one cycle
    localparam int PRECHARGE_CYCLES_RAW = (RAS_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRECHARGE_CYCLES = (PRECHARGE_CYCLES_RAW < 1) ? 1 : PRECHARGE_CYCLES_RAW;
    localparam int FORCED_REFRESH_NS = 300;
    localparam int FORCED_REFRESH_CYCLES_RAW = FORCED_REFRESH_NS / CLK_PERIOD_NS;
    localparam int FORCED_REFRESH_CYCLES = (FORCED_REFRESH_CYCLES_RAW < 1) ? 1 : FORCED_REFRESH_CYCLES_RAW;
    localparam logic [3:0] CNT_RESET = 4'h0;
endpackage

// *** rtl/refresh_arbiter.sv ***
module refresh_arbiter #(
    parameter int CNT_W = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // requests
    input wire logic refreshPeriodClock,
    input wire logic hiddenDone,
    input wire logic dramBusy,
    // results
    output logic forcedActive,
    output logic recovering,
    output logic refreshRequest
);
    // the counter must reach the last cycle of both the refresh and the precharge
    if (CNT_W < 3) begin
        $error("refresh_arbiter counter too narrow");
    end

    typedef struct packed {
        logic clkPrev;
        logic hiddenSeen;
        logic request;
        logic forced;
        logic recover;
        logic [CNT_W-1:0] count;
    } arb_t;

    arb_t cur;
    arb_t next_cur;

    localparam logic [CNT_W-1:0] FR_LAST = CNT_W'(dram_glue_pkg::FORCED_REFRESH_CYCLES - 1);
    localparam logic [CNT_W-1:0] PC_LAST = CNT_W'(dram_glue_pkg::PRECHARGE_CYCLES - 1);

    always_comb begin
        next_cur = cur;
        next_cur.clkPrev = refreshPeriodClock;
        if (refreshPeriodClock && hiddenDone) begin
            next_cur.hiddenSeen = 1'b1;
        end
        if (!refreshPeriodClock && cur.clkPrev) begin
            if (!cur.hiddenSeen && !hiddenDone) begin
                next_cur.request = 1'b1;
            end
            next_cur.hiddenSeen = 1'b0;
        end
        if (cur.forced) begin
            if (cur.count == FR_LAST) begin
                next_cur.forced = 1'b0;
                next_cur.recover = 1'b1;
                next_cur.count = '0;
            end else begin
                next_cur.count = cur.count + 1'b1;
            end
        end else if (cur.recover) begin
            if (cur.count == PC_LAST) begin
                next_cur.recover = 1'b0;
                next_cur.count = '0;
            end else begin
                next_cur.count = cur.count + 1'b1;
            end
        end else if (cur.request && !dramBusy) begin
            next_cur.forced = 1'b1;
            next_cur.request = 1'b0;
            next_cur.count = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign forcedActive = cur.forced;
    assign recovering = cur.recover;
    assign refreshRequest = cur.request;
endmodule

// *** bench/dram_ctrl_model.sv ***
module dram_ctrl_model (
    // clock
    input wire logic sys_clk,
    // from the glue and the processor bus
    input wire logic row_strobe_request,
    input wire logic controller_mode_pin,
    input wire logic anyByteStrobe_n,
    // observations
    output logic [7:0] forcedCount,
    output logic [7:0] rowCount,
    output logic [7:0] colCount
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lastMode = 1'b1;
    logic lastRow = 1'b1;
    logic lastByte = 1'b1;
    initial begin
        forcedCount = 8'h00;
        rowCount = 8'h00;
        colCount = 8'h00;
    end
    always @(posedge sys_clk) begin
        // mode pin low runs one automatic refresh
        if (lastMode === 1'b1 && controller_mode_pin === 1'b0) begin
            forcedCount <= forcedCount + 8'h01;
        end
        if (lastRow === 1'b1 && row_strobe_request === 1'b0 && controller_mode_pin === 1'b1) begin
            rowCount <= rowCount + 8'h01;
        end
        // page mode: column strobes may repeat while the row stays open
        if (row_strobe_request === 1'b0 && lastByte === 1'b1 && anyByteStrobe_n === 1'b0) begin
            // the combined strobe stands in for the external high and low column strobes
            colCount <= colCount + 8'h01;
        end
        lastMode <= controller_mode_pin;
        lastRow <= row_strobe_request;
        lastByte <= anyByteStrobe_n;
    end
endmodule

// *** bench/cpu_dram_refresh_glue_tb_top.sv ***
module cpu_dram_refresh_glue_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REQ = 0, MODE = 1, ADR = 2, ACK = 3, ROW = 4, DONE = 5;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    dram_glue_pkg::cpu_bus_t cpuBus = 5'h1f;
    logic waitOnRead = 1'b0, waitOnWrite = 1'b0, refreshPeriodClock = 1'b0;
    logic hidden_refresh_enable = 1'b1, outputEnable_n = 1'b0;
    logic access_done_flag, row_strobe_request, transfer_ack, access_during_refresh;
    logic controller_mode_pin, refresh_request, outputsDriven_n;
    logic [7:0] forcedCount, rowCount, colCount;
    logic [5:0] outs;
    int nMismatch = 0;
    int testsRun = 0;
    assign outs = {access_done_flag, row_strobe_request, transfer_ack, access_during_refresh,
                   controller_mode_pin, refresh_request};
    initial forever #50 sys_clk = ~sys_clk;
    cpu_dram_refresh_glue u_dut (.sys_clk(sys_clk), .rst(rst), .cpuBus(cpuBus), .waitOnRead(waitOnRead),
        .waitOnWrite(waitOnWrite), .refreshPeriodClock(refreshPeriodClock),
        .hidden_refresh_enable(hidden_refresh_enable), .outputEnable_n(outputEnable_n),
        .access_done_flag(access_done_flag), .row_strobe_request(row_strobe_request),
        .transfer_ack(transfer_ack), .access_during_refresh(access_during_refresh),
        .controller_mode_pin(controller_mode_pin), .refresh_request(refresh_request),
        .outputsDriven_n(outputsDriven_n));
    dram_ctrl_model u_mem (.sys_clk(sys_clk), .row_strobe_request(row_strobe_request),
        .controller_mode_pin(controller_mode_pin), .anyByteStrobe_n(cpuBus.anyByteStrobe_n),
        .forcedCount(forcedCount), .rowCount(rowCount), .colCount(colCount));
    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check_bits(input string what, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            nMismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            #10;
        end
    endtask
    task automatic wait_for(input int k, input logic lvl, input int bound, output int n);
        n = 0;
        while (outs[k] !== lvl && n < bound) begin
            step(1);
            n++;
        end
        if (outs[k] !== lvl) begin
            nMismatch++;
            $display("CHECK FAILED wait on output %0d expected %0b seen %0b", k, lvl, outs[k]);
            conclude();
        end
    endtask
    // byte strobe is the and of both low-active strobes
    task automatic start_access(input logic sel_n, input logic rd, input logic wreq_n);
        cpuBus = {1'b0, sel_n, rd, 1'b0, wreq_n};
    endtask
    task automatic end_access();
        cpuBus = 5'h1f;
        step(1);
        check_bits("outputs after strobe high", 8'h3f, {2'h0, outs});
        step(1);
    endtask
    task automatic t_accesses();
        int n;
        logic rd, wreq_n, slow;
        for (int i = 0; i < 9; i++) begin
            rd = i[0];
            waitOnRead = i[1] | i[3];
            waitOnWrite = i[2] | i[3];
            wreq_n = i[3];
            slow = !wreq_n && (rd ? waitOnRead : waitOnWrite);
            start_access(1'b0, rd, wreq_n);
            step(2);
            check_bits("row request at c1", 8'h00, {7'h0, row_strobe_request});
            wait_for(ACK, 1'b0, 10, n);
            check_bits("ack edge", slow ? 8'h04 : 8'h03, 8'(n + 2));
            wait_for(DONE, 1'b0, 3, n);
            end_access();
        end
    endtask
    task automatic t_tas();
        int n;
        logic [7:0] r0, c0;
        r0 = rowCount;
        c0 = colCount;
        start_access(1'b0, 1'b1, 1'b1);
        wait_for(ROW, 1'b0, 4, n);
        repeat (2) begin
            cpuBus.anyByteStrobe_n = 1'b1;
            step(1);
            cpuBus.anyByteStrobe_n = 1'b0;
            step(1);
        end
        check_bits("row held in read-modify-write", 8'h00, {7'h0, row_strobe_request});
        check_bits("column strobes", c0 + 8'h02, colCount);
        check_bits("row cycles", r0 + 8'h01, rowCount);
        end_access();
    endtask
    task automatic t_oe();
        outputEnable_n = 1'b1;
        start_access(1'b0, 1'b1, 1'b1);
        step(7);
        check_bits("disabled outputs", 8'h7f, {1'b0, outputsDriven_n, outs});
        outputEnable_n = 1'b0;
        step(1);
        check_bits("enabled ack", 8'h00, {7'h0, transfer_ack});
        end_access();
    endtask
    task automatic t_hidden();
        int n;
        logic [7:0] f0;
        f0 = forcedCount;
        refreshPeriodClock = 1'b1;
        start_access(1'b1, 1'b1, 1'b0);
        wait_for(ROW, 1'b0, 4, n);
        step(8);
        check_bits("ack on hidden refresh", 8'h01, {7'h0, transfer_ack});
        check_bits("done on hidden refresh", 8'h00, {7'h0, access_done_flag});
        end_access();
        refreshPeriodClock = 1'b0;
        step(4);
        check_bits("no forced after hidden", f0, forcedCount);
    endtask
    task automatic t_long_foreign();
        int n;
        logic [7:0] f0;
        f0 = forcedCount;
        hidden_refresh_enable = 1'b0;
        refreshPeriodClock = 1'b1;
        start_access(1'b1, 1'b1, 1'b1);
        step(4);
        check_bits("row with hidden refresh off", 8'h01, {7'h0, row_strobe_request});
        refreshPeriodClock = 1'b0;
        wait_for(REQ, 1'b0, 3, n);
        wait_for(MODE, 1'b0, 6, n);
        wait_for(MODE, 1'b1, 10, n);
        check_bits("mode pin low cycles", 8'(dram_glue_pkg::FORCED_REFRESH_CYCLES), 8'(n));
        check_bits("forced refreshes", f0 + 8'h01, forcedCount);
        end_access();
        // a selected access still gets its row request with hidden refresh off
        start_access(1'b0, 1'b1, 1'b1);
        wait_for(ROW, 1'b0, 4, n);
        end_access();
        hidden_refresh_enable = 1'b1;
        step(4);
    endtask
    task automatic t_refresh_wait();
        int n;
        refreshPeriodClock = 1'b1;
        step(3);
        refreshPeriodClock = 1'b0;
        wait_for(MODE, 1'b0, 6, n);
        start_access(1'b0, 1'b1, 1'b1);
        wait_for(ADR, 1'b0, 3, n);
        wait_for(ACK, 1'b0, 20, n);
        check_bits("mode pin at delayed ack", 8'h01, {7'h0, controller_mode_pin});
        check_bits("ack delayed", 8'h01, {7'h0, n > 4});
        end_access();
    endtask
    initial begin
        step(2);
        check_bits("outputs in reset", 8'h3f, {2'h0, outs});
        rst = 1'b0;
        step(2);
        t_accesses();
        t_tas();
        t_oe();
        t_hidden();
        t_long_foreign();
        t_refresh_wait();
        conclude();
    end
endmodule
